// file: cosc_control.v
// Behaviour
// - three frequency strap bits pick processor frequency; bus 33.33 MHz, spread half down
// - straps are sampled only when active-low power-good reads ready
// - high power-down input enters low-power state asynchronously
// - in power-down, internal clocks, loops and oscillator are halted
// - display-or-link strap: 0 gives display or video clock, 1 gives link clock
// - debug strap: 1 gives debug processor pair, 0 gives link pair
// - display-or-video strap: 1 gives display pair, 0 gives 27 MHz clocks
// - shared pins carry display, link or video clocks by both straps
// - the two free bus clocks keep running regardless of bus stop
// - each request input low enables its assigned link outputs, high disables
// - request-select strap 0 gives seventh link pair, 1 gives two request inputs
// - power-save low switches to the preselected underclock table entry
// - in test mode the test input picks high impedance or reference divider
// - test mode is latched from the three-level strap input
// - provide the 96 MHz differential display dot clock
// - drive fixed 48 MHz serial-bus clock on first frequency strap pin
// - reference outputs run at the 14.318 MHz crystal frequency
// - bus stop low holds stoppable bus and link clocks at 0
`include "cosc_defs.vh"
`default_nettype none

module cosc_control #(
	parameter LINK_PAIRS = `COSC_LINK_PAIRS,
	parameter LINK_REQS = `COSC_LINK_REQS
) (
	input wire clock,
	input wire resetn,
	// strap pins and power control
	input wire powerGoodN,
	input wire powerDown,
	input wire cpuFreqSelBit0,
	input wire cpuFreqSelBit1,
	input wire cpuFreqSelBit2,
	input wire displayOrLinkSelect,
	input wire debugPortClockEnable,
	input wire displayOrVideoSelect,
	input wire requestSelect,
	input wire [1:0] testSelectLevel,
	// real-time inputs
	input wire testModeSelect,
	input wire [LINK_REQS-1:0] linkClockRequestN,
	input wire [`COSC_MAP_WIDTH-1:0] linkRequestMap,
	input wire powerSaveN,
	input wire [7:0] underclockEntry,
	input wire busClockStopN,
	// status, frequencies and clock enables
	output wire strapLatched,
	output reg lowPowerState,
	output reg oscillatorRun,
	output reg synthLoopRun,
	output reg internalClockRun,
	output reg [2:0] cpuFreqIndex,
	output reg [`COSC_FREQ_WIDTH-1:0] cpuFreqKhz,
	output reg [`COSC_FREQ_WIDTH-1:0] busFreqKhz,
	output reg spreadDownHalf,
	output reg [1:0] cpuClockRun,
	output reg debugProcessorClockRun,
	output reg [1:0] sharedPairMode,
	output reg displayClockRun,
	output reg videoFixedRun,
	output reg videoSpreadRun,
	output reg [`COSC_FREQ_WIDTH-1:0] videoFreqKhz,
	output reg [LINK_PAIRS-1:0] serialLinkRefClockRun,
	output reg pair7DriveEnable,
	output reg [3:0] busClockRun,
	output reg [1:0] freeBusClockRun,
	output reg displayDotClockRun,
	output reg [`COSC_FREQ_WIDTH-1:0] displayDotFreqKhz,
	output reg usbClockRun,
	output reg [`COSC_FREQ_WIDTH-1:0] usbFreqKhz,
	output reg [1:0] refClockRun,
	output reg [`COSC_FREQ_WIDTH-1:0] refFreqKhz,
	// pin directions and test mode
	output reg [`COSC_PIN_SHARED-1:0] pinDriveEnable,
	output reg testModeActive,
	output reg outputsHighZ,
	output reg outputsRefDivided
);

	// ==========================================================
	// functions

	// processor frequency table, one entry per strap code
	// two codes share one frequency, so the index, not the value, names the code
	function [`COSC_FREQ_WIDTH-1:0] cpuKhz;
		input [2:0] code;
		begin
			case (code)
				3'h0: cpuKhz = `COSC_CPU_KHZ_0;
				3'h1: cpuKhz = `COSC_CPU_KHZ_1;
				3'h2: cpuKhz = `COSC_CPU_KHZ_2;
				3'h3: cpuKhz = `COSC_CPU_KHZ_3;
				3'h4: cpuKhz = `COSC_CPU_KHZ_4;
				3'h5: cpuKhz = `COSC_CPU_KHZ_5;
				3'h6: cpuKhz = `COSC_CPU_KHZ_6;
				default: cpuKhz = `COSC_CPU_KHZ_7;
			endcase
		end
	endfunction

	// link pairs switched off by requests held high; the first two
	// requests only count when their pins are inputs
	// a request pin left high by its owner turns its pairs off
	function [LINK_PAIRS-1:0] requestOff;
		input [`COSC_MAP_WIDTH-1:0] map;
		input [LINK_REQS-1:0] reqN;
		input lowReqsActive;
		integer r;
		begin
			requestOff = {LINK_PAIRS{1'b0}};
			for (r = 0; r < LINK_REQS; r = r + 1)
			begin
				if ((r >= 2 || lowReqsActive) && reqN[r])
					requestOff = requestOff | map[r*LINK_PAIRS +: LINK_PAIRS];
			end
		end
	endfunction

	// ==========================================================
	// strap capture
	wire [`COSC_STRAP_WIDTH-1:0] strapIn;
	wire [`COSC_STRAP_WIDTH-1:0] strap;
	wire testLevelOn;

	// the three-level pin enters test mode only at its enabling level
	assign testLevelOn = (testSelectLevel == `COSC_TEST_LEVEL_ENABLE);
	// bit order matches the strap layout in the shared header
	assign strapIn = {testLevelOn, requestSelect, displayOrVideoSelect, debugPortClockEnable,
		displayOrLinkSelect, cpuFreqSelBit2, cpuFreqSelBit1, cpuFreqSelBit0};

	// the latch survives power-down; only reset clears the captured straps
	cosc_strap_latch #(
		.WIDTH(`COSC_STRAP_WIDTH)
	) strapLatch (
		.clock(clock),
		.resetn(resetn),
		.powerGoodN(powerGoodN),
		.strapIn(strapIn),
		.latched(strapLatched),
		.strapValue(strap)
	);

	// ==========================================================
	// next values
	reg [2:0] next_cpuFreqIndex;
	reg [1:0] next_sharedPairMode;
	reg [LINK_PAIRS-1:0] next_linkRun;
	reg [LINK_PAIRS-1:0] linkPresent;
	reg [3:0] next_busClockRun;
	reg [1:0] next_freeBusClockRun;
	reg [1:0] next_cpuClockRun;
	reg next_debugRun;
	reg next_displayRun;
	reg next_videoRun;
	reg next_dotRun;
	reg next_usbRun;
	reg [1:0] next_refRun;
	reg [`COSC_PIN_SHARED-1:0] next_pinDrive;
	reg next_pair7Drive;
	reg normal;

	always @*
	begin
		// clocks run only with straps held and test mode off
		normal = strapLatched && !strap[`COSC_STRAP_TEST];

		// underclock entry takes over in real time while power-save is low
		if (!powerSaveN)
			next_cpuFreqIndex = underclockEntry[2:0];
		else
			next_cpuFreqIndex = strap[`COSC_STRAP_FS2:`COSC_STRAP_FS0];

		// link strap wins: the display-or-video choice only applies otherwise
		if (strap[`COSC_STRAP_DISP_LINK])
			next_sharedPairMode = `COSC_PAIR_LINK;
		else if (strap[`COSC_STRAP_DISP_VIDEO])
			next_sharedPairMode = `COSC_PAIR_DISPLAY;
		else
			next_sharedPairMode = `COSC_PAIR_VIDEO;

		// pairs 0, 7 and 8 exist only when their shared pins carry link clocks
		linkPresent = {LINK_PAIRS{1'b1}};
		linkPresent[0] = (next_sharedPairMode == `COSC_PAIR_LINK);
		linkPresent[7] = !strap[`COSC_STRAP_REQ_SEL];
		linkPresent[8] = !strap[`COSC_STRAP_DEBUG_EN];

		// stopped by default, so a missed branch can never leave a clock running
		next_linkRun = {LINK_PAIRS{1'b0}};
		next_busClockRun = 4'h0;
		next_freeBusClockRun = 2'h0;
		next_cpuClockRun = 2'h0;
		next_debugRun = 1'b0;
		next_displayRun = 1'b0;
		next_videoRun = 1'b0;
		next_dotRun = 1'b0;
		next_usbRun = 1'b0;
		next_refRun = 2'h0;
		next_pinDrive = {`COSC_PIN_SHARED{1'b0}};
		next_pair7Drive = 1'b0;

		// normal running; test mode keeps every clock enable low
		if (normal)
		begin
			next_linkRun = linkPresent & ~requestOff(linkRequestMap, linkClockRequestN,
				strap[`COSC_STRAP_REQ_SEL]) & {LINK_PAIRS{busClockStopN}};
			next_busClockRun = {4{busClockStopN}};
			next_freeBusClockRun = 2'h3;
			next_cpuClockRun = 2'h3;
			next_debugRun = strap[`COSC_STRAP_DEBUG_EN];
			next_displayRun = (next_sharedPairMode == `COSC_PAIR_DISPLAY);
			next_videoRun = (next_sharedPairMode == `COSC_PAIR_VIDEO);
			next_dotRun = 1'b1;
			next_usbRun = 1'b1;
			next_refRun = 2'h3;
		end

		// shared pins turn to outputs only once their straps are held
		// pin order: [0] freq strap 0 / serial-bus clock, [1] display-or-link / bus clock,
		// [2] debug strap / free bus clock 0, [3] display-or-video / free bus clock 1,
		// [4] request-select / bus clock, [5] three-level test strap / reference 1
		if (strapLatched)
		begin
			next_pinDrive = {`COSC_PIN_SHARED{1'b1}};
			next_pair7Drive = !strap[`COSC_STRAP_REQ_SEL];
		end
	end

	// ==========================================================
	// output flops; power-down clears all but lowPowerState, which it sets, without waiting for an edge
	// because the oscillator that makes the edges is being stopped
	always @(posedge clock or negedge resetn or posedge powerDown)
	begin
		if (!resetn)
		begin
			lowPowerState <= 1'b0;
			oscillatorRun <= 1'b0;
			synthLoopRun <= 1'b0;
			internalClockRun <= 1'b0;
			cpuFreqIndex <= 3'h0;
			cpuFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			busFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			spreadDownHalf <= 1'b0;
			cpuClockRun <= 2'h0;
			debugProcessorClockRun <= 1'b0;
			sharedPairMode <= `COSC_PAIR_DISPLAY;
			displayClockRun <= 1'b0;
			videoFixedRun <= 1'b0;
			videoSpreadRun <= 1'b0;
			videoFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			serialLinkRefClockRun <= {LINK_PAIRS{1'b0}};
			pair7DriveEnable <= 1'b0;
			busClockRun <= 4'h0;
			freeBusClockRun <= 2'h0;
			displayDotClockRun <= 1'b0;
			displayDotFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			usbClockRun <= 1'b0;
			usbFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			refClockRun <= 2'h0;
			refFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			pinDriveEnable <= {`COSC_PIN_SHARED{1'b0}};
			testModeActive <= 1'b0;
			outputsHighZ <= 1'b0;
			outputsRefDivided <= 1'b0;
		end
		// power-down outranks the clock; the strap latch is untouched
		else if (powerDown)
		begin
			lowPowerState <= 1'b1;
			oscillatorRun <= 1'b0;
			synthLoopRun <= 1'b0;
			internalClockRun <= 1'b0;
			cpuFreqIndex <= 3'h0;
			cpuFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			busFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			spreadDownHalf <= 1'b0;
			cpuClockRun <= 2'h0;
			debugProcessorClockRun <= 1'b0;
			sharedPairMode <= `COSC_PAIR_DISPLAY;
			displayClockRun <= 1'b0;
			videoFixedRun <= 1'b0;
			videoSpreadRun <= 1'b0;
			videoFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			serialLinkRefClockRun <= {LINK_PAIRS{1'b0}};
			pair7DriveEnable <= 1'b0;
			busClockRun <= 4'h0;
			freeBusClockRun <= 2'h0;
			displayDotClockRun <= 1'b0;
			displayDotFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			usbClockRun <= 1'b0;
			usbFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			refClockRun <= 2'h0;
			refFreqKhz <= {`COSC_FREQ_WIDTH{1'b0}};
			pinDriveEnable <= {`COSC_PIN_SHARED{1'b0}};
			testModeActive <= 1'b0;
			outputsHighZ <= 1'b0;
			outputsRefDivided <= 1'b0;
		end
		else
		begin
			// running: every flop follows its next value
			lowPowerState <= 1'b0;
			// oscillator and loops run from reset so the straps can be sampled
			oscillatorRun <= 1'b1;
			synthLoopRun <= 1'b1;
			internalClockRun <= 1'b1;

			// processor frequency from straps or underclock, the rest fixed
			cpuFreqIndex <= next_cpuFreqIndex;
			cpuFreqKhz <= cpuKhz(next_cpuFreqIndex);
			busFreqKhz <= `COSC_BUS_KHZ;
			spreadDownHalf <= `COSC_SPREAD_DOWN_HALF;

			// clock enables and shared pair function
			cpuClockRun <= next_cpuClockRun;
			debugProcessorClockRun <= next_debugRun;
			sharedPairMode <= next_sharedPairMode;
			displayClockRun <= next_displayRun;
			videoFixedRun <= next_videoRun;
			videoSpreadRun <= next_videoRun;
			videoFreqKhz <= `COSC_VIDEO_KHZ;
			serialLinkRefClockRun <= next_linkRun;
			pair7DriveEnable <= next_pair7Drive;
			busClockRun <= next_busClockRun;
			freeBusClockRun <= next_freeBusClockRun;
			displayDotClockRun <= next_dotRun;
			displayDotFreqKhz <= `COSC_DOT_KHZ;
			usbClockRun <= next_usbRun;
			usbFreqKhz <= `COSC_USB_KHZ;
			refClockRun <= next_refRun;
			refFreqKhz <= `COSC_REF_KHZ;

			// pin directions
			pinDriveEnable <= next_pinDrive;

			// test input is real time; only the mode itself is latched
			testModeActive <= strapLatched && strap[`COSC_STRAP_TEST];
			outputsHighZ <= strapLatched && strap[`COSC_STRAP_TEST] && !testModeSelect;
			outputsRefDivided <= strapLatched && strap[`COSC_STRAP_TEST] && testModeSelect;
		end
	end

endmodule // cosc_control

`default_nettype wire

// file: cosc_control_checker.sv
`include "cosc_defs.vh"
`default_nettype none

module cosc_control_checker #(
	parameter LINK_PAIRS = 9
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic powerGoodN,
	input wire logic powerDown,
	input wire logic strapLatched,
	input wire logic [5:0] pinDriveEnable,
	input wire logic lowPowerState,
	input wire logic oscillatorRun,
	input wire logic synthLoopRun,
	input wire logic internalClockRun,
	input wire logic [1:0] freeBusClockRun,
	input wire logic [1:0] refClockRun,
	input wire logic usbClockRun,
	input wire logic displayDotClockRun,
	input wire logic testModeActive,
	input wire logic busClockStopN,
	input wire logic [3:0] busClockRun,
	input wire logic [LINK_PAIRS-1:0] serialLinkRefClockRun,
	input wire logic powerSaveN,
	input wire logic [7:0] underclockEntry,
	input wire logic [2:0] cpuFreqIndex,
	input wire logic testModeSelect,
	input wire logic outputsHighZ,
	input wire logic outputsRefDivided
);
	timeunit 1ns;
	timeprecision 1ps;
	logic steadyQ;
	logic steady;
	logic [2:0] underIndex;
	// ========
	// helpers
	// outputs are trusted only after one edge with straps latched and power up
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			steadyQ <= 1'b0;
		else
			steadyQ <= strapLatched && !powerDown;
	end
	// power-down is asynchronous, so it gates the trust at once
	assign steady = steadyQ && !powerDown;
	assign underIndex = underclockEntry[2:0];
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ========
	// properties
	property p_latchTake;
		!strapLatched && !powerGoodN && !powerDown |=> strapLatched;
	endproperty
	a_latchTake: assert property (p_latchTake) else $error("strap not taken");
	property p_latchRefuse;
		!strapLatched && powerGoodN |=> !strapLatched;
	endproperty
	a_latchRefuse: assert property (p_latchRefuse) else $error("strap taken early");
	property p_pinsIn;
		!strapLatched |-> pinDriveEnable == 6'h00;
	endproperty
	a_pinsIn: assert property (p_pinsIn) else $error("pin driven before latch");
	property p_pinsOut;
		steady |-> pinDriveEnable == 6'h3F && oscillatorRun;
	endproperty
	a_pinsOut: assert property (p_pinsOut) else $error("pins not driven");
	property p_powerDown;
		powerDown |-> lowPowerState && !oscillatorRun && !synthLoopRun && !internalClockRun;
	endproperty
	a_powerDown: assert property (p_powerDown) else $error("power-down ignored");
	property p_freeRun;
		steady && !testModeActive |-> freeBusClockRun == 2'h3 && refClockRun == 2'h3
			&& usbClockRun && displayDotClockRun;
	endproperty
	a_freeRun: assert property (p_freeRun) else $error("fixed clock stopped");
	property p_busStop;
		steady && !$past(busClockStopN) |-> busClockRun == 4'h0 && serialLinkRefClockRun == '0;
	endproperty
	a_busStop: assert property (p_busStop) else $error("stoppable clock runs");
	property p_powerSave;
		steady && !$past(powerSaveN) |-> cpuFreqIndex == $past(underIndex);
	endproperty
	a_powerSave: assert property (p_powerSave) else $error("underclock index wrong");
	property p_testMode;
		steady && testModeActive |-> outputsRefDivided == $past(testModeSelect) && outputsHighZ != $past(testModeSelect);
	endproperty
	a_testMode: assert property (p_testMode) else $error("test output mode wrong");
endmodule // cosc_control_checker

bind cosc_control cosc_control_checker #(.LINK_PAIRS(LINK_PAIRS)) i_cosc_control_checker (
	.clock(clock), .resetn(resetn), .powerGoodN(powerGoodN), .powerDown(powerDown), .strapLatched(strapLatched),
	.pinDriveEnable(pinDriveEnable), .lowPowerState(lowPowerState), .oscillatorRun(oscillatorRun),
	.synthLoopRun(synthLoopRun), .internalClockRun(internalClockRun), .freeBusClockRun(freeBusClockRun),
	.refClockRun(refClockRun), .usbClockRun(usbClockRun), .displayDotClockRun(displayDotClockRun),
	.testModeActive(testModeActive), .busClockStopN(busClockStopN), .busClockRun(busClockRun),
	.serialLinkRefClockRun(serialLinkRefClockRun), .powerSaveN(powerSaveN), .underclockEntry(underclockEntry),
	.cpuFreqIndex(cpuFreqIndex), .testModeSelect(testModeSelect), .outputsHighZ(outputsHighZ),
	.outputsRefDivided(outputsRefDivided)
);

`default_nettype wire

// file: cosc_defs.vh
`ifndef COSC_DEFS_VH
`define COSC_DEFS_VH

// ==========================================================
// strap vector layout
`define COSC_STRAP_WIDTH 8
`define COSC_STRAP_FS0 0
`define COSC_STRAP_FS1 1
`define COSC_STRAP_FS2 2
`define COSC_STRAP_DISP_LINK 3
`define COSC_STRAP_DEBUG_EN 4
`define COSC_STRAP_DISP_VIDEO 5
`define COSC_STRAP_REQ_SEL 6
`define COSC_STRAP_TEST 7

// three-level strap encoding from the input comparator
`define COSC_TEST_LEVEL_ENABLE 2'h2

// ==========================================================
// shared pair modes
`define COSC_PAIR_DISPLAY 2'h0
`define COSC_PAIR_LINK 2'h1
`define COSC_PAIR_VIDEO 2'h2

// ==========================================================
// output counts
`define COSC_LINK_PAIRS 9
`define COSC_LINK_REQS 4
`define COSC_MAP_WIDTH 36
`define COSC_PIN_SHARED 6

// ==========================================================
// frequencies in kHz
`define COSC_FREQ_WIDTH 19
`define COSC_CPU_KHZ_0 19'h411A4
`define COSC_CPU_KHZ_1 19'h208D2
`define COSC_CPU_KHZ_2 19'h30D40
`define COSC_CPU_KHZ_3 19'h28B04
`define COSC_CPU_KHZ_4 19'h51612
`define COSC_CPU_KHZ_5 19'h186A0
`define COSC_CPU_KHZ_6 19'h61A80
`define COSC_CPU_KHZ_7 19'h30D40
`define COSC_BUS_KHZ 19'h08232
`define COSC_DOT_KHZ 19'h17700
`define COSC_USB_KHZ 19'h0BB80
`define COSC_REF_KHZ 19'h037EE
`define COSC_VIDEO_KHZ 19'h06978
`define COSC_SPREAD_DOWN_HALF 1'h1

`endif

// file: cosc_far_side.sv
`default_nettype none

module cosc_far_side (
	input wire logic ready,
	input wire logic [6:0] strapCfg,
	input wire logic [1:0] testLevel,
	input wire logic strapLatched,
	output logic powerGoodN,
	output logic [6:0] strapPin,
	output logic [1:0] testSelectLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// platform side
	// power-good follows the sequencer, active low
	assign powerGoodN = !ready;
	// straps stay valid until latched; then the pins are outputs, so show stale-inverse levels
	assign strapPin = strapLatched ? ~strapCfg : strapCfg;
	assign testSelectLevel = strapLatched ? ~testLevel : testLevel;
endmodule // cosc_far_side

`default_nettype wire

// file: cosc_strap_latch.v
`default_nettype none

// ==========================================================
// strap capture: takes the strap levels once, on the first cycle
// that power-good reads ready, and keeps them until reset
module cosc_strap_latch #(
	parameter WIDTH = 8
) (
	input wire clock,
	input wire resetn,
	input wire powerGoodN,
	input wire [WIDTH-1:0] strapIn,
	output reg latched,
	output reg [WIDTH-1:0] strapValue
);

	// capture once; later power-good changes are ignored so that the
	// shared pins may start driving clocks without corrupting the value
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			latched <= 1'b0;
			strapValue <= {WIDTH{1'b0}};
		end
		else if (!powerGoodN && !latched)
		begin
			latched <= 1'b1;
			strapValue <= strapIn;
		end
	end

endmodule // cosc_strap_latch

`default_nettype wire

// file: test_clock_output_select_control.sv
`include "cosc_defs.vh"
`default_nettype none

module test_clock_output_select_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, resetn = 0, powerDown = 0, ready = 0, testModeSelect = 0, powerSaveN = 1, busClockStopN = 1;
	logic [6:0] strapCfg = 7'h00;
	logic [1:0] testLevel = 2'h0;
	logic [3:0] linkClockRequestN = 4'h0;
	logic [35:0] linkRequestMap = {9'h100, 9'h010, 9'h004, 9'h002};
	logic [7:0] underclockEntry = 8'h00;
	wire logic [6:0] strapPin;
	wire logic [1:0] testSelectLevel;
	wire logic powerGoodN, cpuFreqSelBit0, cpuFreqSelBit1, cpuFreqSelBit2;
	wire logic displayOrLinkSelect, debugPortClockEnable, displayOrVideoSelect, requestSelect;
	logic strapLatched, lowPowerState, oscillatorRun, synthLoopRun, internalClockRun, spreadDownHalf;
	logic debugProcessorClockRun, displayClockRun, videoFixedRun, videoSpreadRun, pair7DriveEnable;
	logic displayDotClockRun, usbClockRun, testModeActive, outputsHighZ, outputsRefDivided;
	logic [2:0] cpuFreqIndex;
	logic [18:0] cpuFreqKhz, busFreqKhz, videoFreqKhz, displayDotFreqKhz, usbFreqKhz, refFreqKhz;
	logic [1:0] cpuClockRun, sharedPairMode, freeBusClockRun, refClockRun;
	logic [8:0] serialLinkRefClockRun;
	logic [3:0] busClockRun;
	logic [5:0] pinDriveEnable;
	logic [18:0] cpuTab [8] = '{19'h411A4, 19'h208D2, 19'h30D40, 19'h28B04, 19'h51612, 19'h186A0, 19'h61A80, 19'h30D40};
	int err_count = 0;
	int cmp_count = 0;
	// ========
	// harness
	assign {requestSelect, displayOrVideoSelect, debugPortClockEnable, displayOrLinkSelect} = strapPin[6:3];
	assign {cpuFreqSelBit2, cpuFreqSelBit1, cpuFreqSelBit0} = strapPin[2:0];
	cosc_far_side i_cosc_far_side (.ready(ready), .strapCfg(strapCfg), .testLevel(testLevel),
		.strapLatched(strapLatched), .powerGoodN(powerGoodN), .strapPin(strapPin), .testSelectLevel(testSelectLevel));
	cosc_control i_cosc_control (
		.clock(clock), .resetn(resetn), .powerGoodN(powerGoodN), .powerDown(powerDown),
		.cpuFreqSelBit0(cpuFreqSelBit0), .cpuFreqSelBit1(cpuFreqSelBit1), .cpuFreqSelBit2(cpuFreqSelBit2),
		.displayOrLinkSelect(displayOrLinkSelect), .debugPortClockEnable(debugPortClockEnable),
		.displayOrVideoSelect(displayOrVideoSelect), .requestSelect(requestSelect),
		.testSelectLevel(testSelectLevel), .testModeSelect(testModeSelect),
		.linkClockRequestN(linkClockRequestN), .linkRequestMap(linkRequestMap),
		.powerSaveN(powerSaveN), .underclockEntry(underclockEntry), .busClockStopN(busClockStopN),
		.strapLatched(strapLatched), .lowPowerState(lowPowerState), .oscillatorRun(oscillatorRun),
		.synthLoopRun(synthLoopRun), .internalClockRun(internalClockRun), .cpuFreqIndex(cpuFreqIndex),
		.cpuFreqKhz(cpuFreqKhz), .busFreqKhz(busFreqKhz), .spreadDownHalf(spreadDownHalf),
		.cpuClockRun(cpuClockRun), .debugProcessorClockRun(debugProcessorClockRun),
		.sharedPairMode(sharedPairMode), .displayClockRun(displayClockRun), .videoFixedRun(videoFixedRun),
		.videoSpreadRun(videoSpreadRun), .videoFreqKhz(videoFreqKhz),
		.serialLinkRefClockRun(serialLinkRefClockRun), .pair7DriveEnable(pair7DriveEnable),
		.busClockRun(busClockRun), .freeBusClockRun(freeBusClockRun), .displayDotClockRun(displayDotClockRun),
		.displayDotFreqKhz(displayDotFreqKhz), .usbClockRun(usbClockRun), .usbFreqKhz(usbFreqKhz),
		.refClockRun(refClockRun), .refFreqKhz(refFreqKhz), .pinDriveEnable(pinDriveEnable),
		.testModeActive(testModeActive), .outputsHighZ(outputsHighZ), .outputsRefDivided(outputsRefDivided)
	);
	// 40 MHz clock
	initial
	begin
		forever #12.5 clock = ~clock;
	end
	// ========
	// tasks
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clock);
	endtask
	// straps are the only write path: each set needs a fresh reset
	task automatic bringUp(input logic [6:0] c, input logic [1:0] lv);
		resetn = 0;
		ready = 0;
		strapCfg = c;
		testLevel = lv;
		step(16);
		resetn = 1;
		step(2);
		check({strapLatched, pinDriveEnable}, 7'h00);
		ready = 1;
		step(3);
		check({strapLatched, pinDriveEnable}, 7'h7F);
	endtask
	// link pairs present by straps, minus pairs of requests held high
	function automatic logic [8:0] expLink(input logic [6:0] c);
		logic [8:0] e;
		e = {!c[4], !c[6], 6'h3F, c[3]};
		for (int r = 0; r < 4; r++)
			if (linkClockRequestN[r] && (r > 1 || c[6]))
				e = e & ~linkRequestMap[r * 9 +: 9];
		return busClockStopN ? e : 9'h000;
	endfunction
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ========
	// tests
	initial
	begin
		logic [6:0] c;
		for (int k = 0; k < 8; k++)
		begin
			c = {k[0], k[1], k[2], k[1] ^ k[0], k[2:0]};
			bringUp(c, {1'b0, k[0]});
			check(cpuFreqKhz, cpuTab[k]);
			check({cpuClockRun, spreadDownHalf, busFreqKhz}, {2'h3, 1'b1, 19'h08232});
			check(sharedPairMode, c[3] ? 2'h1 : (c[5] ? 2'h0 : 2'h2));
			check({displayClockRun, videoFixedRun, videoSpreadRun}, {!c[3] && c[5], {2{!c[3] && !c[5]}}});
			check(videoFreqKhz, 19'h06978);
			check({debugProcessorClockRun, pair7DriveEnable, testModeActive}, {c[4], !c[6], 1'b0});
			check(displayDotFreqKhz, 19'h17700);
			check(usbFreqKhz, 19'h0BB80);
			check(refFreqKhz, 19'h037EE);
			for (int r = 0; r < 5; r++)
			begin
				linkClockRequestN = 4'h1 << r;
				step(2);
				check(serialLinkRefClockRun, expLink(c));
			end
		end
		$display("test straps done");
		busClockStopN = 0;
		step(2);
		check({busClockRun, serialLinkRefClockRun, freeBusClockRun}, 15'h0003);
		busClockStopN = 1;
		step(2);
		check(busClockRun, 4'hF);
		$display("test bus stop done");
		powerSaveN = 0;
		underclockEntry = 8'hF5;
		step(2);
		check(cpuFreqKhz, cpuTab[5]);
		powerSaveN = 1;
		step(2);
		check(cpuFreqKhz, cpuTab[7]);
		$display("test power save done");
		ready = 0;
		powerDown = 1;
		#1;
		check({lowPowerState, oscillatorRun, synthLoopRun, internalClockRun}, 4'h8);
		step(3);
		powerDown = 0;
		step(2);
		check({lowPowerState, oscillatorRun, strapLatched, pinDriveEnable}, 9'h0FF);
		$display("test power down done");
		bringUp(7'h00, 2'h2);
		check(testModeActive, 1'b1);
		for (int s = 0; s < 2; s++)
		begin
			testModeSelect = s[0];
			step(2);
			check({outputsHighZ, outputsRefDivided, freeBusClockRun, cpuClockRun}, {~s[0], s[0], 4'h0});
		end
		$display("test mode done");
		test_done;
	end
	// watchdog
	initial
	begin
		#(25 * 2000);
		err_count++;
		test_done;
	end
endmodule // test_clock_output_select_control

`default_nettype wire
